// ---- include/rre_regs.vh ----
// Purpose: Shared constants of the return and rotate execution block.
// Assumes: Included by bare name from every design file of the block except the rotate datapath.
// Notes: Opcode patterns are compared after masking with the matching mask.
`ifndef RRE_REGS_VH
`define RRE_REGS_VH

// Opcode patterns and masks.
`define RRE_OP_INT_RET 16'h0010
`define RRE_OP_RETURN 16'h0012
`define RRE_MASK_SHADOW 16'hFFFE
`define RRE_OP_LIT_RET 16'h0C00
`define RRE_MASK_LIT_RET 16'hFF00
`define RRE_OP_ROT_LEFT 16'h3400
`define RRE_MASK_ROT_LEFT 16'hFC00

// Instruction field positions.
`define RRE_BIT_SHADOW 0
`define RRE_BIT_ACCESS 8
`define RRE_BIT_DEST 9
`define RRE_LIT_MSB 7

// Status register bit positions.
`define RRE_ST_C 0
`define RRE_ST_Z 2
`define RRE_ST_N 4

// Control register bit positions.
`define RRE_CT_LOW_EN 0
`define RRE_CT_HIGH_EN 1
`define RRE_CT_IPEN 2
`define RRE_CT_EXTEN 3

// Register port addresses.
`define RRE_ADDR_W 4'h0
`define RRE_ADDR_STATUS 4'h1
`define RRE_ADDR_BANK 4'h2
`define RRE_ADDR_CTRL 4'h3
`define RRE_ADDR_W_SHD 4'h4
`define RRE_ADDR_ST_SHD 4'h5
`define RRE_ADDR_BANK_SHD 4'h6
`define RRE_ADDR_PCL 4'h7
`define RRE_ADDR_PCH 4'h8
`define RRE_ADDR_PCU 4'h9

// Reset values.
`define RRE_RST_BYTE 8'h00
`define RRE_RST_BANK 4'h0
`define RRE_RST_PC 21'h000000
`define RRE_RST_ADDR 12'h000

// Data memory addressing.
`define RRE_INDEX_LIMIT 8'h5F
`define RRE_ACCESS_HIGH_BANK 4'hF
`define RRE_ACCESS_LOW_BANK 4'h0

`endif

// ---- hdl/rre_addr_gen.v ----
// Purpose: Forms the data memory address of a byte-oriented operand.
// Assumes: Purely combinational; all inputs come from the core clock domain.
// Notes: The indexed form adds the literal offset to the index base.
`timescale 1ns/1ps
`include "rre_regs.vh"
module rre_addr_gen #(
    parameter ADDR_W = 12
) (
    input wire [7:0] fileAddr,
    input wire accessSel,
    input wire [3:0] bankSel,
    input wire extEnable,
    input wire [ADDR_W-1:0] indexBase,
    output reg [ADDR_W-1:0] dataAddr,
    output reg indexed
);
    always @* begin
        indexed = 1'b0;
        if (accessSel) begin
            dataAddr = {bankSel, fileAddr}; // RQ9
        end else if (extEnable && (fileAddr <= `RRE_INDEX_LIMIT)) begin
            indexed = 1'b1;
            dataAddr = indexBase + {4'h0, fileAddr}; // RQ10
        end else if (fileAddr <= `RRE_INDEX_LIMIT) begin
            dataAddr = {`RRE_ACCESS_LOW_BANK, fileAddr}; // RQ9
        end else begin
            dataAddr = {`RRE_ACCESS_HIGH_BANK, fileAddr}; // RQ9
        end
    end
endmodule // rre_addr_gen

// ---- hdl/rre_rotate.v ----
// Purpose: Rotate-left-through-carry datapath with its flag results.
// Assumes: Purely combinational.
// Notes: Zero and negative describe the rotated byte, not the source byte.
`timescale 1ns/1ps
module rre_rotate #(
    parameter DATA_W = 8
) (
    input wire [DATA_W-1:0] dataIn,
    input wire carryIn,
    output wire [DATA_W-1:0] result,
    output wire carryOut,
    output wire negOut,
    output wire zeroOut
);
    assign result = {dataIn[DATA_W-2:0], carryIn}; // RQ7
    assign carryOut = dataIn[DATA_W-1]; // RQ7
    assign negOut = result[DATA_W-1]; // RQ7
    assign zeroOut = ~|result; // RQ7
endmodule // rre_rotate

// ---- hdl/rre_exec.v ----
// Purpose: Executes return-from-interrupt, return-with-literal, return and rotate-left-carry.
// Assumes: Stack, data memory and index base live outside on the same clock.
// Notes: Other opcodes are accepted and retired in one cycle with no effect.
// Function
// RQ1 - The return-from-interrupt opcode pops the stack into the program counter, low bit selects shadows.
// RQ2 - Return-from-interrupt sets the high or low priority global enable and changes no other status.
// RQ3 - With the shadow flag at 1 both interrupt and subroutine returns restore W, status and bank select from shadows.
// RQ4 - Returns never touch the program counter upper and high latches, only the program counter.
// RQ5 - Return-with-literal loads its 8-bit literal into W, pops the stack, takes two cycles, no flags.
// RQ6 - Return-from-subroutine pops the stack into the program counter in two cycles with no flag change.
// RQ7 - Rotate-left-carry shifts the byte left, bit 7 to carry, old carry to bit 0, updating C, N and Z.
// RQ8 - The rotate destination bit at 0 writes W, at 1 writes back to the file register.
// RQ9 - The rotate access bit at 0 uses the access bank, at 1 the bank select register picks the bank.
// RQ10 - With the extended set on and access bit 0, file addresses up to 95 use indexed literal offset.
// RQ11 - Two-cycle returns finish all updates at the end of the first cycle, the second cycle is a no-op.
`timescale 1ns/1ps
`include "rre_regs.vh"
module rre_exec #(
    parameter PC_W = 21,
    parameter ADDR_W = 12
) (
    input wire clk,
    input wire arst_n,
    input wire instrValid,
    input wire [15:0] instrWord,
    output reg instrReady_q,
    input wire [PC_W-1:0] topOfStack,
    output reg stackPop_q,
    output reg [PC_W-1:0] pc_q,
    input wire [ADDR_W-1:0] indexBase,
    output reg [ADDR_W-1:0] memAddr_q,
    output reg memRdEn_q,
    input wire [7:0] memRdData,
    output reg memWrEn_q,
    output reg [7:0] memWrData_q,
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrStrobe,
    input wire regRdStrobe,
    output reg [7:0] regRdData_q,
    output reg [7:0] workingReg_q,
    output reg [7:0] statusReg_q,
    output reg [3:0] bankSelectRegister_q,
    output reg highPriorityGlobalEnable_q,
    output reg lowPriorityGlobalEnable_q
);
    localparam ST_IDLE = 3'b001;
    localparam ST_NOP = 3'b010;
    localparam ST_ROT = 3'b100;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [7:0] workingShadow_q;
    reg [7:0] statusShadow_q;
    reg [3:0] bankSelectShadow_q;
    reg priorityEnable_q;
    reg extendedEnable_q;
    reg rotDest_q;

    wire issue;
    wire isIntRet;
    wire isReturn;
    wire isLitRet;
    wire isRotLeft;
    wire shadowSel;
    wire doPop;
    wire doRestore;
    wire [ADDR_W-1:0] operandAddr;
    wire [7:0] rotResult;
    wire rotCarry;
    wire rotNeg;
    wire rotZero;
    wire swWrite;
    reg [7:0] regRdData_d;

    assign issue = instrValid & state_q[0];
    assign isIntRet = ((instrWord & `RRE_MASK_SHADOW) == `RRE_OP_INT_RET); // RQ1
    assign isReturn = ((instrWord & `RRE_MASK_SHADOW) == `RRE_OP_RETURN); // RQ6
    assign isLitRet = ((instrWord & `RRE_MASK_LIT_RET) == `RRE_OP_LIT_RET); // RQ5
    assign isRotLeft = ((instrWord & `RRE_MASK_ROT_LEFT) == `RRE_OP_ROT_LEFT); // RQ7
    assign shadowSel = instrWord[`RRE_BIT_SHADOW];
    assign doPop = issue & (isIntRet | isReturn | isLitRet);
    assign doRestore = issue & (isIntRet | isReturn) & shadowSel; // RQ3
    assign swWrite = regWrStrobe;

    rre_addr_gen #(
        .ADDR_W(ADDR_W)
    ) uAddrGen (
        .fileAddr(instrWord[`RRE_LIT_MSB:0]),
        .accessSel(instrWord[`RRE_BIT_ACCESS]),
        .bankSel(bankSelectRegister_q),
        .extEnable(extendedEnable_q),
        .indexBase(indexBase),
        .dataAddr(operandAddr),
        .indexed()
    );

    rre_rotate #(
        .DATA_W(8)
    ) uRotate (
        .dataIn(memRdData),
        .carryIn(statusReg_q[`RRE_ST_C]),
        .result(rotResult),
        .carryOut(rotCarry),
        .negOut(rotNeg),
        .zeroOut(rotZero)
    );

    // A two-cycle return retires its work on the accepting edge and then idles one cycle,
    // which stands in for the refill of the fetch pipeline.
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (doPop) begin
                    state_d = ST_NOP; // RQ11
                end else if (issue && isRotLeft) begin
                    state_d = ST_ROT;
                end
            end
            ST_NOP: begin
                state_d = ST_IDLE;
            end
            ST_ROT: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            instrReady_q <= 1'b1;
        end else begin
            state_q <= state_d;
            instrReady_q <= (state_d == ST_IDLE);
        end
    end

    // Program counter and stack pop; the address latches are not part of this block
    // and nothing here drives them.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_q <= `RRE_RST_PC;
            stackPop_q <= 1'b0;
        end else begin
            stackPop_q <= doPop; // RQ1
            if (doPop) begin
                pc_q <= topOfStack; // RQ4
            end
        end
    end

    // Data memory access for the rotate: address in the decode cycle, data back one
    // cycle later. This costs one extra clock against a single-cycle rotate.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            memAddr_q <= `RRE_RST_ADDR;
            memRdEn_q <= 1'b0;
            memWrEn_q <= 1'b0;
            memWrData_q <= `RRE_RST_BYTE;
            rotDest_q <= 1'b0;
        end else begin
            memRdEn_q <= issue & isRotLeft;
            memWrEn_q <= 1'b0;
            if (issue && isRotLeft) begin
                memAddr_q <= operandAddr; // RQ9
                rotDest_q <= instrWord[`RRE_BIT_DEST];
            end
            if (state_q[2] && rotDest_q) begin
                memWrEn_q <= 1'b1; // RQ8
                memWrData_q <= rotResult;
            end
        end
    end

    // Architectural registers. Hardware updates come after software writes so that an
    // instruction landing in the same cycle as a register write wins.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            workingReg_q <= `RRE_RST_BYTE;
            statusReg_q <= `RRE_RST_BYTE;
            bankSelectRegister_q <= `RRE_RST_BANK;
            workingShadow_q <= `RRE_RST_BYTE;
            statusShadow_q <= `RRE_RST_BYTE;
            bankSelectShadow_q <= `RRE_RST_BANK;
            highPriorityGlobalEnable_q <= 1'b0;
            lowPriorityGlobalEnable_q <= 1'b0;
            priorityEnable_q <= 1'b0;
            extendedEnable_q <= 1'b0;
        end else begin
            if (swWrite) begin
                case (regAddr)
                    `RRE_ADDR_W: begin
                        workingReg_q <= regWrData;
                    end
                    `RRE_ADDR_STATUS: begin
                        statusReg_q <= regWrData;
                    end
                    `RRE_ADDR_BANK: begin
                        bankSelectRegister_q <= regWrData[3:0];
                    end
                    `RRE_ADDR_CTRL: begin
                        lowPriorityGlobalEnable_q <= regWrData[`RRE_CT_LOW_EN];
                        highPriorityGlobalEnable_q <= regWrData[`RRE_CT_HIGH_EN];
                        priorityEnable_q <= regWrData[`RRE_CT_IPEN];
                        extendedEnable_q <= regWrData[`RRE_CT_EXTEN];
                    end
                    `RRE_ADDR_W_SHD: begin
                        workingShadow_q <= regWrData;
                    end
                    `RRE_ADDR_ST_SHD: begin
                        statusShadow_q <= regWrData;
                    end
                    `RRE_ADDR_BANK_SHD: begin
                        bankSelectShadow_q <= regWrData[3:0];
                    end
                    default: begin
                    end
                endcase
            end
            // Without priorities the high enable is the single global enable. With them,
            // the high level is re-armed first, since it is the one a high ISR cleared.
            if (issue && isIntRet) begin
                if (!priorityEnable_q || !highPriorityGlobalEnable_q) begin
                    highPriorityGlobalEnable_q <= 1'b1; // RQ2
                end else begin
                    lowPriorityGlobalEnable_q <= 1'b1; // RQ2
                end
            end
            if (doRestore) begin
                workingReg_q <= workingShadow_q; // RQ3
                statusReg_q <= statusShadow_q; // RQ3
                bankSelectRegister_q <= bankSelectShadow_q; // RQ3
            end
            if (issue && isLitRet) begin
                workingReg_q <= instrWord[`RRE_LIT_MSB:0]; // RQ5
            end
            if (state_q[2]) begin
                statusReg_q[`RRE_ST_C] <= rotCarry; // RQ7
                statusReg_q[`RRE_ST_N] <= rotNeg; // RQ7
                statusReg_q[`RRE_ST_Z] <= rotZero; // RQ7
                if (!rotDest_q) begin
                    workingReg_q <= rotResult; // RQ8
                end
            end
        end
    end

    // Register read mux. Without a strobe the port reads 0, so the data stand for
    // exactly one cycle after the strobe and a stale byte is never seen twice.
    always @* begin
        regRdData_d = `RRE_RST_BYTE;
        if (regRdStrobe) begin
            case (regAddr)
                `RRE_ADDR_W: begin
                    regRdData_d = workingReg_q;
                end
                `RRE_ADDR_STATUS: begin
                    regRdData_d = statusReg_q;
                end
                `RRE_ADDR_BANK: begin
                    regRdData_d = {4'h0, bankSelectRegister_q};
                end
                `RRE_ADDR_CTRL: begin
                    regRdData_d = {4'h0, extendedEnable_q, priorityEnable_q,
                        highPriorityGlobalEnable_q, lowPriorityGlobalEnable_q};
                end
                `RRE_ADDR_W_SHD: begin
                    regRdData_d = workingShadow_q;
                end
                `RRE_ADDR_ST_SHD: begin
                    regRdData_d = statusShadow_q;
                end
                `RRE_ADDR_BANK_SHD: begin
                    regRdData_d = {4'h0, bankSelectShadow_q};
                end
                `RRE_ADDR_PCL: begin
                    regRdData_d = pc_q[7:0];
                end
                `RRE_ADDR_PCH: begin
                    regRdData_d = pc_q[15:8];
                end
                `RRE_ADDR_PCU: begin
                    regRdData_d = {3'h0, pc_q[PC_W-1:16]};
                end
                default: begin
                    regRdData_d = `RRE_RST_BYTE;
                end
            endcase
        end
    end

    // The program counter bytes are not latched together; software that reads them
    // while a return retires may see a torn value.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData_q <= `RRE_RST_BYTE;
        end else begin
            regRdData_q <= regRdData_d;
        end
    end

endmodule // rre_exec

// ---- bench/rre_exec_sva.sv ----
// Purpose: Assertions on the instruction port and register outputs of rre_exec.
// Assumes: Bound to every rre_exec instance; one clock domain.
// Notes: Software writes in the accept cycle are excluded where a register is checked to stay stable.
`timescale 1ns/1ps
`include "rre_regs.vh"
module rre_exec_sva #(
    parameter PC_W = 21
) (
    input wire clk,
    input wire arst_n,
    input wire instrValid,
    input wire [15:0] instrWord,
    input wire instrReady_q,
    input wire [PC_W-1:0] topOfStack,
    input wire stackPop_q,
    input wire [PC_W-1:0] pc_q,
    input wire memRdEn_q,
    input wire [7:0] memRdData,
    input wire memWrEn_q,
    input wire [7:0] memWrData_q,
    input wire regWrStrobe,
    input wire [7:0] workingReg_q,
    input wire [7:0] statusReg_q,
    input wire [3:0] bankSelectRegister_q,
    input wire highPriorityGlobalEnable_q
);
    wire take = instrValid & instrReady_q;
    wire intRet = take && (instrWord & `RRE_MASK_SHADOW) == `RRE_OP_INT_RET;
    wire subRet = take && (instrWord & `RRE_MASK_SHADOW) == `RRE_OP_RETURN;
    wire litRet = take && (instrWord & `RRE_MASK_LIT_RET) == `RRE_OP_LIT_RET;
    wire anyRet = intRet | subRet | litRet;
    wire rotWb = take && (instrWord & `RRE_MASK_ROT_LEFT) == `RRE_OP_ROT_LEFT
        && instrWord[`RRE_BIT_DEST];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_pop_pulse: assert property (anyRet |=> stackPop_q && !instrReady_q ##1
        !stackPop_q && instrReady_q) else $error("pop pulse or ready wrong after return");
    a_pc_from_stack: assert property (anyRet |=> pc_q == $past(topOfStack))
        else $error("pc not loaded from stack top");
    a_literal_to_w: assert property (litRet |=> workingReg_q == $past(instrWord[7:0]))
        else $error("literal not loaded into working register");
    a_enable_set: assert property (intRet && !highPriorityGlobalEnable_q
        |=> highPriorityGlobalEnable_q) else $error("high enable not set by interrupt return");
    a_shadow_keep: assert property ((intRet || subRet) && !instrWord[0] && !regWrStrobe
        |=> $stable(workingReg_q) && $stable(statusReg_q) && $stable(bankSelectRegister_q))
        else $error("registers changed without shadow select");
    a_literal_flags: assert property (litRet && !regWrStrobe
        |=> $stable(statusReg_q) && $stable(bankSelectRegister_q))
        else $error("literal return changed status");
    a_ret_no_mem: assert property (anyRet |=> !memRdEn_q && !memWrEn_q)
        else $error("return touched data memory");
    a_rot_write: assert property (rotWb |=> memRdEn_q ##1 (memWrEn_q
        && memWrData_q == {$past(memRdData[6:0]), $past(statusReg_q[`RRE_ST_C])}
        && statusReg_q[`RRE_ST_C] == $past(memRdData[7]))) else $error("rotate result wrong");
    a_rot_flags: assert property (memWrEn_q |-> statusReg_q[`RRE_ST_Z] == (memWrData_q == 8'h00)
        && statusReg_q[`RRE_ST_N] == memWrData_q[7]) else $error("rotate zero or negative wrong");
    a_second_idle: assert property (stackPop_q |=> !stackPop_q && !memRdEn_q && $stable(pc_q))
        else $error("second return cycle not idle");
endmodule // rre_exec_sva

bind rre_exec rre_exec_sva #(.PC_W(PC_W)) rre_exec_sva_inst (.*);

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for rre_exec against an integer model.
// Assumes: Register port and instruction port driven one request at a time.
// Notes: Status is written with C, Z and N only, so reserved bits never matter.
`timescale 1ns/1ps
`include "rre_regs.vh"
module testbench;
    logic clk, arst_n, instrValid, regWrStrobe, regRdStrobe;
    logic [15:0] instrWord;
    logic [20:0] topOfStack;
    logic [11:0] indexBase, memAddr_q;
    logic [7:0] memRdData, regWrData, memWrData_q, regRdData_q, workingReg_q, statusReg_q;
    logic [3:0] regAddr, bankSelectRegister_q;
    logic instrReady_q, stackPop_q, memRdEn_q, memWrEn_q;
    logic highPriorityGlobalEnable_q, lowPriorityGlobalEnable_q;
    logic [20:0] pc_q;
    logic [7:0] fv [3];
    integer fails = 0, check_count = 0, cycles = 0;
    integer w, st, bank_select_register, ws, sts, bss, ctl, gh, gl, pc;

    rre_exec rre_exec_inst (.*);

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            conclude();
        end
    end

    task conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task tick();
        @(posedge clk);
        #1;
    endtask

    // Each register access leaves one idle cycle so a strobe is never re-driven in one step.
    task wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'h1;
        tick();
        regWrStrobe <= 1'h0;
        tick();
    endtask

    task rdChk(input logic [3:0] a, input integer e);
        regAddr <= a;
        regRdStrobe <= 1'h1;
        tick();
        regRdStrobe <= 1'h0;
        chk("regRdData", e, regRdData_q);
        tick();
    endtask

    task chkAll();
        chk("W", w, workingReg_q);
        chk("STATUS", st, statusReg_q);
        chk("bank", bank_select_register, bankSelectRegister_q);
        chk("highEn", gh, highPriorityGlobalEnable_q);
        chk("lowEn", gl, lowPriorityGlobalEnable_q);
        chk("pc", pc, pc_q);
    endtask

    task setCtl(input logic [7:0] v);
        wr(`RRE_ADDR_CTRL, v);
        ctl = v;
        gl = v[0];
        gh = v[1];
    endtask

    task randRegs();
        w = $urandom & 8'hFF;
        st = $urandom & 8'h15;
        bank_select_register = $urandom & 8'h0F;
        wr(`RRE_ADDR_W, w);
        wr(`RRE_ADDR_STATUS, st);
        wr(`RRE_ADDR_BANK, bank_select_register);
    endtask

    task ret(input logic [15:0] op);
        pc = $urandom & 21'h1FFFFF;
        topOfStack <= pc;
        instrWord <= op;
        instrValid <= 1'h1;
        tick();
        instrValid <= 1'h0;
        topOfStack <= ~topOfStack;
        if (op[15:8] == 8'h0C) w = op[7:0];
        else if (op[0]) begin
            w = ws;
            st = sts;
            bank_select_register = bss;
        end
        if (op[7:1] == 7'h08 && op[15:8] == 8'h00) begin
            if (!ctl[2] || !gh) gh = 1;
            else gl = 1;
        end
        chk("stackPop", 1, stackPop_q);
        chk("ready", 0, instrReady_q);
        chkAll();
        tick();
        chk("stackPop", 0, stackPop_q);
        chk("ready", 1, instrReady_q);
    endtask

    task rot(input logic d, input logic a, input logic [7:0] f);
        logic [7:0] data, res;
        logic [11:0] adr;
        data = $urandom;
        res = {data[6:0], st[0]};
        if (a) adr = {bank_select_register[3:0], f};
        else if (ctl[3] && f <= 8'h5F) adr = indexBase + f;
        else adr = {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
        instrWord <= {6'h0D, d, a, f};
        instrValid <= 1'h1;
        tick();
        instrValid <= 1'h0;
        memRdData <= data;
        chk("memRdEn", 1, memRdEn_q);
        chk("memAddr", adr, memAddr_q);
        tick();
        memRdData <= ~data;
        st = (st & 8'hEA) | data[7] | ((res == 8'h00) << 2) | (res[7] << 4);
        if (!d) w = res;
        chk("memWrEn", d, memWrEn_q);
        if (d) chk("memWrData", res, memWrData_q);
        chkAll();
    endtask

    initial begin
        void'($urandom(32'h5E647213));
        arst_n = 1'h0;
        instrValid = 1'h0;
        instrWord = 16'h0000;
        topOfStack = 21'h000000;
        indexBase = $urandom;
        memRdData = 8'h00;
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWrStrobe = 1'h0;
        regRdStrobe = 1'h0;
        {w, st, bank_select_register, ws, sts, bss, ctl, gh, gl, pc} = '0;
        fv = '{8'h5F, 8'h60, 8'($urandom)};
        repeat (20) @(posedge clk);
        arst_n <= 1'h1;
        tick();
        chk("ready", 1, instrReady_q);
        chkAll();
        rdChk(4'hF, 0);
        for (int i = 0; i < 8; i++) begin
            if (i[1:0] == 2'h0) setCtl(i[2] ? 8'h04 : 8'h00);
            randRegs();
            ws = $urandom & 8'hFF;
            sts = $urandom & 8'h15;
            bss = $urandom & 8'h0F;
            wr(`RRE_ADDR_W_SHD, ws);
            wr(`RRE_ADDR_ST_SHD, sts);
            wr(`RRE_ADDR_BANK_SHD, bss);
            rdChk(`RRE_ADDR_ST_SHD, sts);
            ret({14'h0004, i[1:0]});
        end
        ret({8'h0C, 8'h00});
        ret({8'h0C, 8'hFF});
        ret(16'h0012);
        wr(`RRE_ADDR_PCL, 8'hA5);
        rdChk(`RRE_ADDR_PCL, pc & 8'hFF);
        rdChk(`RRE_ADDR_PCH, (pc >> 8) & 8'hFF);
        rdChk(`RRE_ADDR_PCU, (pc >> 16) & 8'h1F);
        rdChk(`RRE_ADDR_CTRL, (ctl & 8'h0C) | (gh << 1) | gl);
        rdChk(`RRE_ADDR_W, w);
        for (int j = 0; j < 24; j++) begin
            if (j % 12 == 0) setCtl(j < 12 ? 8'h00 : 8'h08);
            randRegs();
            rot(j[0], j[1], fv[(j / 4) % 3]);
        end
        conclude();
    end
endmodule // testbench
